// ==== rtl/ifp_params.svh ====
// Register map, field positions and reset values of the interrupt flag/enable/priority bank
`ifndef IFP_PARAMS_SVH
`define IFP_PARAMS_SVH

`define IFP_OFS_CTRL      12'h000
`define IFP_OFS_RELOAD    12'h004
`define IFP_OFS_FLAG      12'h008
`define IFP_OFS_ENABLE    12'h00C
`define IFP_OFS_PRIO0     12'h010
`define IFP_OFS_PRIO1     12'h014
`define IFP_OFS_PRIO2     12'h018
`define IFP_OFS_PRIO3     12'h01C
`define IFP_OFS_TIMER     12'h020
`define IFP_OFS_EVSTAT    12'h024
`define IFP_OFS_EVMASK    12'h028
`define IFP_OFS_ACTIVE    12'h02C
`define IFP_OFS_PRIO4     12'h030
`define IFP_OFS_PRIO5     12'h034
`define IFP_OFS_PRIO6     12'h038
`define IFP_OFS_PRIO7     12'h03C

`define IFP_ZERO32        32'h0000_0000
`define IFP_ONE32         32'h0000_0001
`define IFP_PRIO_MASK     32'h1F1F_1F1F
`define IFP_THR_LSB       8
`define IFP_THR_MSB       10
`define IFP_PRI_LSB       2
`define IFP_PRI_MSB       4
`define IFP_SUB_LSB       0
`define IFP_SUB_MSB       1
`define IFP_SLOT_BITS     8
`define IFP_PRIO_WORDS    8
`define IFP_PRIO_SPLIT    4
`define IFP_WORD_BYTES    4
`define IFP_EV_REQ        0
`define IFP_EV_EXPIRE     1

`endif

// ==== rtl/ifp_pkg.sv ====
// Types shared by the interrupt flag/enable/priority bank
package ifp_pkg;
   typedef struct packed {
      logic [2:0] priority_level;
      logic [1:0] subpriority;
   } ifp_slot_t;

   typedef struct packed {
      logic valid;
      logic [4:0] source;
      ifp_slot_t slot;
   } ifp_request_t;

   typedef enum logic [1:0] {
      IFP_TMR_IDLE = 2'b00,
      IFP_TMR_RUN = 2'b01,
      IFP_TMR_DONE = 2'b10
   } ifp_tmr_state_t;
endpackage

// ==== rtl/ifp_bank.sv ====
// Interrupt flag, enable and priority register bank with proximity timer, APB slave
`include "ifp_params.svh"

module ifp_bank (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral request pulses, one per source
   input wire logic [31:0] source_request,
   // Toward the processor core
   output ifp_pkg::ifp_request_t core_request,
   output logic proximity_expired,
   output logic irq
);
   import ifp_pkg::*;

   logic rst_meta;
   logic rst_sync_n;
   logic [31:0] request_flag_bits;
   logic [31:0] source_enable_bits;
   logic [31:0] proximity_reload_value;
   logic [31:0] prio_word [0:`IFP_PRIO_WORDS-1];
   logic [2:0] proximity_threshold;
   logic [31:0] timer_count;
   ifp_tmr_state_t tmr_state;
   logic [1:0] ev_status;
   logic [1:0] ev_mask;
   logic [31:0] active_bits;
   ifp_request_t next_request;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic trigger;
   logic [1:0] ev_set;
   logic [31:0] flag_set;

   // Reset release through two flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   function automatic ifp_slot_t slot_of(input logic [4:0] src);
      logic [31:0] w;
      logic [7:0] b;
      // Source i sits in word i/4, byte i%4, so no two sources share a slot
      w = prio_word[src[4:2]];
      b = w[src[1:0]*`IFP_SLOT_BITS +: `IFP_SLOT_BITS];
      slot_of.priority_level = b[`IFP_PRI_MSB:`IFP_PRI_LSB];
      slot_of.subpriority = b[`IFP_SUB_MSB:`IFP_SUB_LSB];
   endfunction

   function automatic logic is_mapped(input logic [11:0] a);
      case (a)
         `IFP_OFS_CTRL, `IFP_OFS_RELOAD, `IFP_OFS_FLAG, `IFP_OFS_ENABLE,
         `IFP_OFS_PRIO0, `IFP_OFS_PRIO1, `IFP_OFS_PRIO2, `IFP_OFS_PRIO3,
         `IFP_OFS_PRIO4, `IFP_OFS_PRIO5, `IFP_OFS_PRIO6, `IFP_OFS_PRIO7,
         `IFP_OFS_TIMER, `IFP_OFS_EVSTAT, `IFP_OFS_EVMASK, `IFP_OFS_ACTIVE:
            is_mapped = 1'b1;
         default:
            is_mapped = 1'b0;
      endcase
   endfunction

   // Priority words 0-3 sit below the timer, words 4-7 above the active word
   function automatic logic [11:0] prio_addr(input int k);
      if (k < `IFP_PRIO_SPLIT) begin
         prio_addr = `IFP_OFS_PRIO0 + 12'(`IFP_WORD_BYTES * k);
      end else begin
         prio_addr = `IFP_OFS_PRIO4 + 12'(`IFP_WORD_BYTES * (k - `IFP_PRIO_SPLIT));
      end
   endfunction

   // Zero-wait slave: access phase completes in its first cycle
   assign pready = 1'b1;
   assign addr_ok = is_mapped(paddr);
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en = psel & penable & pwrite & addr_ok;
   assign rd_en = psel & ~penable & ~pwrite;

   // Pending-and-permitted sources
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         active_bits[i] = request_flag_bits[i] & source_enable_bits[i]
                          & (slot_of(5'(i)).priority_level != 3'b000);
      end
   end

   // Highest priority, then highest subpriority, then lowest source number
   always_comb begin
      ifp_slot_t s;
      next_request = '0;
      s = '0;
      for (int i = 0; i < 32; i++) begin
         s = slot_of(5'(i));
         if (active_bits[i] && (!next_request.valid
             || s.priority_level > next_request.slot.priority_level
             || (s.priority_level == next_request.slot.priority_level
                 && s.subpriority > next_request.slot.subpriority))) begin
            next_request.valid = 1'b1;
            next_request.source = 5'(i);
            next_request.slot = s;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         core_request <= '0;
      end else begin
         core_request <= next_request;
      end
   end

   // Rising edge of a newly selected request in the threshold group starts the timer
   assign trigger = next_request.valid && (proximity_threshold != 3'b000)
                    && (next_request.slot.priority_level <= proximity_threshold)
                    && (!core_request.valid
                        || next_request.source != core_request.source);

   assign flag_set = source_request;

   // Request flags: a source pulse wins over a software write in the same cycle
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         request_flag_bits <= `IFP_ZERO32;
      end else if (wr_en && paddr == `IFP_OFS_FLAG) begin
         request_flag_bits <= pwdata | flag_set;
      end else begin
         request_flag_bits <= request_flag_bits | flag_set;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         source_enable_bits <= `IFP_ZERO32;
      end else if (wr_en && paddr == `IFP_OFS_ENABLE) begin
         source_enable_bits <= pwdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         proximity_reload_value <= `IFP_ZERO32;
         proximity_threshold <= 3'b000;
         ev_mask <= 2'b00;
      end else if (wr_en) begin
         case (paddr)
            `IFP_OFS_RELOAD: proximity_reload_value <= pwdata;
            `IFP_OFS_CTRL: proximity_threshold <= pwdata[`IFP_THR_MSB:`IFP_THR_LSB];
            `IFP_OFS_EVMASK: ev_mask <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int k = 0; k < `IFP_PRIO_WORDS; k++) begin
            prio_word[k] <= `IFP_ZERO32;
         end
      end else if (wr_en) begin
         for (int k = 0; k < `IFP_PRIO_WORDS; k++) begin
            if (paddr == prio_addr(k)) begin
               prio_word[k] <= pwdata & `IFP_PRIO_MASK;
            end
         end
      end
   end

   // Proximity timer: counts down from reload, retriggered by each newly selected request in the threshold group
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tmr_state <= IFP_TMR_IDLE;
         timer_count <= `IFP_ZERO32;
      end else if (trigger) begin
         timer_count <= proximity_reload_value;
         tmr_state <= IFP_TMR_RUN;
      end else begin
         case (tmr_state)
            IFP_TMR_IDLE: tmr_state <= IFP_TMR_IDLE;
            IFP_TMR_RUN: begin
               if (proximity_threshold == 3'b000) begin
                  tmr_state <= IFP_TMR_IDLE;
               end else if (timer_count == `IFP_ZERO32) begin
                  tmr_state <= IFP_TMR_DONE;
               end else begin
                  timer_count <= timer_count - `IFP_ONE32;
               end
            end
            IFP_TMR_DONE: tmr_state <= IFP_TMR_IDLE;
            default: tmr_state <= IFP_TMR_IDLE;
         endcase
      end
   end

   assign proximity_expired = (tmr_state == IFP_TMR_DONE);

   // Event status: set wins over write-one-to-clear
   assign ev_set = {proximity_expired, next_request.valid & ~core_request.valid};

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ev_status <= 2'b00;
      end else if (wr_en && paddr == `IFP_OFS_EVSTAT) begin
         ev_status <= (ev_status & ~pwdata[1:0]) | ev_set;
      end else begin
         ev_status <= ev_status | ev_set;
      end
   end

   assign irq = |(ev_status & ev_mask);

   // Read data registered in the setup phase, valid through the access phase
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prdata <= `IFP_ZERO32;
      end else if (rd_en) begin
         case (paddr)
            `IFP_OFS_CTRL: prdata <= 32'(proximity_threshold) << `IFP_THR_LSB;
            `IFP_OFS_RELOAD: prdata <= proximity_reload_value;
            `IFP_OFS_FLAG: prdata <= request_flag_bits;
            `IFP_OFS_ENABLE: prdata <= source_enable_bits;
            `IFP_OFS_PRIO0: prdata <= prio_word[0];
            `IFP_OFS_PRIO1: prdata <= prio_word[1];
            `IFP_OFS_PRIO2: prdata <= prio_word[2];
            `IFP_OFS_PRIO3: prdata <= prio_word[3];
            `IFP_OFS_PRIO4: prdata <= prio_word[4];
            `IFP_OFS_PRIO5: prdata <= prio_word[5];
            `IFP_OFS_PRIO6: prdata <= prio_word[6];
            `IFP_OFS_PRIO7: prdata <= prio_word[7];
            `IFP_OFS_TIMER: prdata <= timer_count;
            `IFP_OFS_EVSTAT: prdata <= {30'h0000_0000, ev_status};
            `IFP_OFS_EVMASK: prdata <= {30'h0000_0000, ev_mask};
            `IFP_OFS_ACTIVE: prdata <= active_bits;
            default: prdata <= `IFP_ZERO32;
         endcase
      end
   end

   chk_reload_on_trigger: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      trigger |=> timer_count == $past(proximity_reload_value))
      else $error("timer did not load reload value");

   chk_count_down: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      (tmr_state == IFP_TMR_RUN && proximity_threshold != 3'b000
       && timer_count != `IFP_ZERO32 && !trigger)
      |=> timer_count == $past(timer_count) - `IFP_ONE32)
      else $error("timer did not count down");

   chk_expire_pulse: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      proximity_expired |=> !proximity_expired)
      else $error("expiry pulse longer than one cycle");

   // A clear in the same cycle must not hide the expiry
   chk_expire_sets_status: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      proximity_expired |=> ev_status[`IFP_EV_EXPIRE])
      else $error("expiry did not set event status");

   chk_flag_sticky: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      source_request[0] |=> request_flag_bits[0])
      else $error("flag not set by request");

   chk_flags_hold: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      (!wr_en && source_request == `IFP_ZERO32) |=> $stable(request_flag_bits))
      else $error("flag changed with no request or write");

   chk_flag_write: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      (wr_en && paddr == `IFP_OFS_FLAG && source_request == 32'h0)
      |=> request_flag_bits == $past(pwdata))
      else $error("flag write not stored");

   chk_enable_gate: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      !source_enable_bits[0] |-> !active_bits[0])
      else $error("disabled source active");

   chk_enable_hold: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      !(wr_en && paddr == `IFP_OFS_ENABLE) |=> $stable(source_enable_bits))
      else $error("enable changed without a write");

   chk_zero_prio_off: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      next_request.valid |-> next_request.slot.priority_level != 3'b000)
      else $error("zero priority presented");

   chk_sub_order: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      (active_bits[0] && active_bits[1] && slot_of(5'd0) == slot_of(5'd1))
      |-> next_request.source != 5'd1)
      else $error("tie not broken by lowest source");

   chk_slot_layout: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      slot_of(5'd3).priority_level == prio_word[0][28:26])
      else $error("slot 3 priority field misplaced");

   chk_prio_reserved: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      (prio_word[1] & ~`IFP_PRIO_MASK) == 32'h0)
      else $error("reserved priority bits set");

   chk_threshold_off: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      proximity_threshold == 3'b000 |-> !trigger)
      else $error("timer triggered while disabled");

   // The source index is taken now, the active word one cycle back
   chk_presented: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      core_request.valid |-> |($past(active_bits) & (`IFP_ONE32 << core_request.source)))
      else $error("presented source not active");

   chk_unmapped_zero: assert property (@(posedge ref_clk)
      disable iff (!rst_sync_n)
      (psel && !penable && !pwrite && !addr_ok) |=> prdata == `IFP_ZERO32)
      else $error("unmapped read not zero");

   chk_reset_zero: assert property (@(posedge ref_clk)
      !rst_sync_n |=> (request_flag_bits == 32'h0 && source_enable_bits == 32'h0
                       && proximity_reload_value == 32'h0))
      else $error("bank not zero after reset");
endmodule

// ==== verification/ifp_core_model.sv ====
// Core-side model that records what the bank presents and counts timer expiries
module ifp_core_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // From the bank
   input wire ifp_pkg::ifp_request_t core_request,
   input wire logic proximity_expired,
   // Seen by the bench
   output logic [7:0] expired_count,
   output logic [4:0] last_source
);
   import ifp_pkg::*;
   // Only a valid request is taken; the source field of an idle bus means nothing
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         last_source <= 5'h00;
      end else if (core_request.valid) begin
         last_source <= core_request.source;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         expired_count <= 8'h00;
      end else if (proximity_expired) begin
         expired_count <= expired_count + 8'h01;
      end
   end
endmodule

// ==== verification/test_interrupt_flag_enable_priority_bank.sv ====
// Self-checking bench of the interrupt flag, enable and priority bank
`include "ifp_params.svh"
module test_interrupt_flag_enable_priority_bank;
   timeunit 1ns;
   timeprecision 1ns;
   import ifp_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn, psel, penable, pwrite, pready, pslverr, proximity_expired, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, source_request, rd;
   ifp_request_t core_request;
   logic [7:0] expired_count, base;
   logic [4:0] last_source;
   int miscompares = 0;
   int compares = 0;
   int n;
   always #50 ref_clk = ~ref_clk;
   ifp_bank i_ifp_bank (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .source_request(source_request), .core_request(core_request),
      .proximity_expired(proximity_expired), .irq(irq));
   ifp_core_model i_ifp_core_model (.ref_clk(ref_clk), .resetn(resetn),
      .core_request(core_request), .proximity_expired(proximity_expired),
      .expired_count(expired_count), .last_source(last_source));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] req(input logic [4:0] s, input logic [2:0] p,
      input logic [1:0] q);
      return {21'h000000, 1'b1, s, p, q};
   endfunction
   // Idle edge before each setup so no signal is assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic look();
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic pulse(input logic [31:0] m);
      @(posedge ref_clk);
      source_request <= m;
      @(posedge ref_clk);
      source_request <= 32'h00000000;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 16; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
   endtask
   task automatic t_regs();
      apb(1'b1, `IFP_OFS_RELOAD, 32'hA5A55A5A);
      apb(1'b0, `IFP_OFS_RELOAD, 32'h0);
      chk(rd, 32'hA5A55A5A);
      apb(1'b1, `IFP_OFS_ENABLE, 32'h5A5AA5A5);
      apb(1'b0, `IFP_OFS_ENABLE, 32'h0);
      chk(rd, 32'h5A5AA5A5);
      apb(1'b1, `IFP_OFS_PRIO2, 32'hFFFFFFFF);
      apb(1'b0, `IFP_OFS_PRIO2, 32'h0);
      chk(rd, 32'h1F1F1F1F);
      apb(1'b1, 12'h040, 32'hFFFFFFFF);
      apb(1'b0, 12'h040, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1'b1, `IFP_OFS_ENABLE, 32'h0);
   endtask
   task automatic t_irq();
      // Source 0 must be presentable for its request to raise the event
      apb(1'b1, `IFP_OFS_PRIO0, 32'h10);
      apb(1'b1, `IFP_OFS_ENABLE, 32'h1);
      apb(1'b1, `IFP_OFS_EVSTAT, 32'h3);
      pulse(32'h1);
      apb(1'b0, `IFP_OFS_FLAG, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, `IFP_OFS_EVSTAT, 32'h0);
      chk({rd[0], irq}, 32'h2);
      apb(1'b1, `IFP_OFS_EVMASK, 32'h1);
      look();
      chk(irq, 32'h1);
      apb(1'b1, `IFP_OFS_EVSTAT, 32'h1);
      apb(1'b1, `IFP_OFS_FLAG, 32'h0);
      apb(1'b0, `IFP_OFS_FLAG, 32'h0);
      chk({rd[0], irq}, 32'h0);
   endtask
   task automatic t_timer();
      apb(1'b1, `IFP_OFS_RELOAD, 32'h14);
      apb(1'b1, `IFP_OFS_CTRL, 32'h700);
      apb(1'b1, `IFP_OFS_PRIO0, 32'h10);
      apb(1'b1, `IFP_OFS_ENABLE, 32'h1);
      base = expired_count;
      pulse(32'h1);
      n = 0;
      while (expired_count === base && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(n >= 17 && n <= 25), 32'h1);
      // Threshold 000 and a threshold below the source priority must both stay silent
      for (int t = 0; t < 2; t++) begin
         apb(1'b1, `IFP_OFS_FLAG, 32'h0);
         apb(1'b1, `IFP_OFS_CTRL, t ? 32'h300 : 32'h0);
         pulse(32'h1);
         repeat (40) @(posedge ref_clk);
         chk(expired_count, base + 8'h01);
      end
   endtask
   task automatic t_arb();
      apb(1'b1, `IFP_OFS_FLAG, 32'h0);
      apb(1'b1, `IFP_OFS_PRIO0, 32'h000E0D14);
      apb(1'b1, `IFP_OFS_PRIO1, 32'h1C000000);
      apb(1'b1, `IFP_OFS_ENABLE, 32'hE);
      pulse(32'hF);
      @(negedge ref_clk);
      chk(32'(core_request), req(5'h02, 3'h3, 2'h2));
      apb(1'b1, `IFP_OFS_ENABLE, 32'hF);
      look();
      chk(32'(core_request), req(5'h00, 3'h5, 2'h0));
      apb(1'b1, `IFP_OFS_FLAG, 32'hA);
      look();
      chk(32'(core_request), req(5'h01, 3'h3, 2'h1));
      apb(1'b1, `IFP_OFS_FLAG, 32'h8);
      look();
      chk(core_request.valid, 32'h0);
      apb(1'b1, `IFP_OFS_ENABLE, 32'h8E);
      pulse(32'h80);
      @(negedge ref_clk);
      chk(32'(core_request), req(5'h07, 3'h7, 2'h0));
      chk(last_source, 32'h7);
      // Equal slots fall to the lower source number
      apb(1'b1, `IFP_OFS_PRIO0, 32'h00001414);
      apb(1'b1, `IFP_OFS_ENABLE, 32'h80000003);
      apb(1'b1, `IFP_OFS_FLAG, 32'h00000003);
      look();
      chk(32'(core_request), req(5'h00, 3'h5, 2'h0));
      apb(1'b1, `IFP_OFS_PRIO7, 32'h1C000000);
      pulse(32'h80000000);
      @(negedge ref_clk);
      chk(32'(core_request), req(5'h1F, 3'h7, 2'h0));
   endtask
   task automatic tally_and_finish();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      source_request = 32'h0;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_regs();
      t_irq();
      t_timer();
      t_arb();
      tally_and_finish();
   end
   // Whole run is well under a thousand cycles
   initial begin
      #1000000;
      miscompares++;
      tally_and_finish();
   end
endmodule
